// ==== hdl/xds_regs.svh ====
`ifndef XDS_REGS_SVH
`define XDS_REGS_SVH

// core clocks per machine cycle
`define XDS_MC_CLKS 4
// machine cycles of an on-chip data SRAM access, and the base of a bus access
`define XDS_ONCHIP_MCS 2
`define XDS_BUS_BASE_MCS 2
// clocks at the start of a bus access during which the address latch strobe is high
`define XDS_ALE_CLKS 2

// data space
`define XDS_XRAM_LAST 16'h03ff
`define XDS_XRAM_AW 10
`define XDS_SCRATCH_AW 8

// special function register space
`define XDS_SFR_BASE 8'h80
`define XDS_CSC_ADDR 8'h8e
`define XDS_MEC_ADDR 8'hc4
`define XDS_CSC_RST 8'h01
`define XDS_XEN_RST 1'b0
`define XDS_XEN_BIT 0
`define XDS_STR_MSB 2
`define XDS_STR_LSB 0
`define XDS_UNIMPL_READ 8'hff

`endif

// ==== hdl/xds_pkg.sv ====
`default_nettype none

package xds_pkg;

    // external data move request
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xds_move_t;

    // internal register space request
    typedef struct packed {
        logic write;
        logic indirect;
        logic bitop;
        logic [2:0] bitsel;
        logic bitval;
        logic [7:0] addr;
        logic [7:0] wdata;
    } xds_ireg_t;

    typedef enum logic [2:0] {
        XDS_IDLE = 3'b001,
        XDS_ONCHIP = 3'b010,
        XDS_BUS = 3'b100
    } xds_state_t;

endpackage

`default_nettype wire

// ==== hdl/xds_ram.sv ====
`timescale 1ns/1ns
`default_nettype none

module xds_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read side, combinational
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // no reset: storage contents are undefined after power-up
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
    end

    assign rdata = mem_q[raddr];

endmodule

`default_nettype wire

// ==== hdl/xds_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "xds_regs.svh"

module xds_decoder (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // external data move from the core
    input wire logic XMOVE_REQ,
    input wire xds_pkg::xds_move_t XMOVE_CMD,
    output logic XMOVE_BUSY,
    output logic XMOVE_DONE,
    output logic [7:0] XMOVE_RDATA,
    output logic XMOVE_ONCHIP,
    // internal register space from the core
    input wire logic IREG_REQ,
    input wire xds_pkg::xds_ireg_t IREG_CMD,
    output logic IREG_DONE,
    output logic [7:0] IREG_RDATA,
    output logic IREG_REFUSED,
    // port latch values for general I/O use
    input wire logic [7:0] P0_LATCH,
    input wire logic [7:0] P2_LATCH,
    // external multiplexed bus
    output logic ALE,
    output logic RD_N,
    output logic WR_N,
    input wire logic [7:0] P0_IN,
    output logic [7:0] P0_OUT,
    output logic [7:0] P0_OE_N,
    output logic [7:0] P2_OUT,
    output logic [7:0] P2_OE_N,
    // configuration status
    output logic [2:0] STRETCH,
    output logic XRAM_ENABLED
);

    // clocks of an access lasting the given number of machine cycles
    function automatic logic [5:0] mc_to_clks(input logic [3:0] mcs);
        logic [5:0] wide;
        wide = {2'b00, mcs};
        mc_to_clks = 6'(wide * 6'(`XDS_MC_CLKS));
    endfunction

    // replace one bit, keep the rest
    function automatic logic [7:0] merge_bit(input logic [7:0] old, input logic [2:0] sel,
                                             input logic val);
        logic [7:0] mask;
        mask = 8'h01 << sel;
        merge_bit = (old & ~mask) | (val ? mask : 8'h00);
    endfunction

    // configuration registers
    logic [7:0] csc_q;
    logic [7:0] csc_d;
    logic xen_q;
    logic xen_d;

    // move state
    xds_pkg::xds_state_t state_q;
    xds_pkg::xds_state_t state_d;
    logic [5:0] cyc_q;
    logic [5:0] cyc_d;
    logic [5:0] len_q;
    logic [5:0] len_d;
    xds_pkg::xds_move_t cmd_q;
    xds_pkg::xds_move_t cmd_d;

    // internal register space decode
    wire [7:0] ireg_addr = IREG_CMD.addr;
    wire is_sfr = !IREG_CMD.indirect && ireg_addr >= `XDS_SFR_BASE;
    wire sfr_bitable = ireg_addr[2:0] == 3'h0;
    wire hit_csc = is_sfr && ireg_addr == `XDS_CSC_ADDR;
    wire hit_mec = is_sfr && ireg_addr == `XDS_MEC_ADDR;
    wire [7:0] mec_read = {7'h7f, xen_q};
    wire [7:0] sfr_read = hit_csc ? csc_q : hit_mec ? mec_read : `XDS_UNIMPL_READ;
    wire [7:0] scratch_rdata;
    wire [7:0] old_val = is_sfr ? sfr_read : scratch_rdata;
    wire refuse = IREG_REQ && IREG_CMD.bitop && is_sfr && !sfr_bitable;
    wire [7:0] new_val = IREG_CMD.bitop ?
        merge_bit(old_val, IREG_CMD.bitsel, IREG_CMD.bitval) : IREG_CMD.wdata;
    wire ireg_wr = IREG_REQ && IREG_CMD.write && !refuse;
    wire scratch_we = ireg_wr && !is_sfr;
    wire [7:0] bit_read = {7'h00, old_val[IREG_CMD.bitsel]};
    wire [7:0] ireg_rdata_d = refuse ? `XDS_UNIMPL_READ :
        IREG_CMD.bitop ? bit_read : old_val;

    // data move decode
    wire [2:0] stretch = csc_q[`XDS_STR_MSB:`XDS_STR_LSB];
    wire in_xram_range = XMOVE_CMD.addr <= `XDS_XRAM_LAST;
    wire go_onchip = xen_q && in_xram_range;
    wire [3:0] bus_mcs = 4'({1'b0, stretch} + 4'(`XDS_BUS_BASE_MCS));
    wire [5:0] onchip_len = mc_to_clks(4'(`XDS_ONCHIP_MCS));
    wire [5:0] bus_len = mc_to_clks(bus_mcs);
    wire start = XMOVE_REQ && state_q == xds_pkg::XDS_IDLE;
    wire last = state_q != xds_pkg::XDS_IDLE && cyc_q == 6'(len_q - 6'h01);
    wire bus_sample = state_q == xds_pkg::XDS_BUS && !cmd_q.write &&
        cyc_q == 6'(len_q - 6'h02);
    wire xram_we = last && state_q == xds_pkg::XDS_ONCHIP && cmd_q.write;
    wire [7:0] xram_rdata;

    // next state of the move sequencer
    always_comb
    begin
        state_d = state_q;
        cyc_d = cyc_q;
        len_d = len_q;
        cmd_d = cmd_q;
        unique case (state_q)
            xds_pkg::XDS_IDLE:
            begin
                cyc_d = 6'h00;
                if (start)
                begin
                    cmd_d = XMOVE_CMD;
                    len_d = go_onchip ? onchip_len : bus_len;
                    state_d = go_onchip ? xds_pkg::XDS_ONCHIP : xds_pkg::XDS_BUS;
                end
            end
            xds_pkg::XDS_ONCHIP, xds_pkg::XDS_BUS:
            begin
                if (last)
                begin
                    state_d = xds_pkg::XDS_IDLE;
                    cyc_d = 6'h00;
                end
                else
                begin
                    cyc_d = 6'(cyc_q + 6'h01);
                end
            end
            default:
            begin
                state_d = xds_pkg::XDS_IDLE;
                cyc_d = 6'h00;
            end
        endcase
    end

    // bus pins for the cycle the sequencer moves to
    wire on_bus_d = state_d == xds_pkg::XDS_BUS;
    wire addr_phase_d = cyc_d < 6'(`XDS_ALE_CLKS);
    wire strobe_d = on_bus_d && cyc_d >= 6'(`XDS_MC_CLKS) && cyc_d <= 6'(len_d - 6'h02);
    wire ale_d = on_bus_d && addr_phase_d;
    wire rd_n_d = !(strobe_d && !cmd_d.write);
    wire wr_n_d = !(strobe_d && cmd_d.write);
    wire p0_drive_d = on_bus_d && (addr_phase_d || cmd_d.write);
    wire [7:0] p0_out_d = !on_bus_d ? 8'h00 :
        addr_phase_d ? cmd_d.addr[7:0] : cmd_d.wdata;
    // general use: open drain, low is driven and high floats
    wire [7:0] p0_oe_n_d = on_bus_d ? {8{!p0_drive_d}} : P0_LATCH;
    wire [7:0] p2_out_d = on_bus_d ? cmd_d.addr[15:8] : P2_LATCH;
    wire [7:0] p2_oe_n_d = on_bus_d ? 8'h00 : 8'hff;

    // internal register writes
    always_comb
    begin
        csc_d = csc_q;
        xen_d = xen_q;
        if (ireg_wr && hit_csc)
        begin
            csc_d = new_val;
        end
        if (ireg_wr && hit_mec)
        begin
            xen_d = new_val[`XDS_XEN_BIT];
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            csc_q <= `XDS_CSC_RST;
            xen_q <= `XDS_XEN_RST;
        end
        else
        begin
            csc_q <= csc_d;
            xen_q <= xen_d;
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state_q <= xds_pkg::XDS_IDLE;
            cyc_q <= 6'h00;
            len_q <= 6'h00;
            cmd_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cyc_q <= cyc_d;
            len_q <= len_d;
            cmd_q <= cmd_d;
        end
    end

    // core-facing answers of a data move
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            XMOVE_BUSY <= 1'b0;
            XMOVE_DONE <= 1'b0;
            XMOVE_RDATA <= 8'h00;
            XMOVE_ONCHIP <= 1'b0;
        end
        else
        begin
            XMOVE_BUSY <= state_d != xds_pkg::XDS_IDLE;
            XMOVE_DONE <= last;
            if (start)
            begin
                XMOVE_ONCHIP <= go_onchip;
            end
            if (bus_sample)
            begin
                XMOVE_RDATA <= P0_IN;
            end
            else if (last && state_q == xds_pkg::XDS_ONCHIP && !cmd_q.write)
            begin
                XMOVE_RDATA <= xram_rdata;
            end
        end
    end

    // core-facing answers of the internal register space
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            IREG_DONE <= 1'b0;
            IREG_RDATA <= 8'h00;
            IREG_REFUSED <= 1'b0;
        end
        else
        begin
            IREG_DONE <= IREG_REQ;
            IREG_REFUSED <= refuse;
            if (IREG_REQ)
            begin
                IREG_RDATA <= ireg_rdata_d;
            end
        end
    end

    // external bus pins, idle levels from reset
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ALE <= 1'b0;
            RD_N <= 1'b1;
            WR_N <= 1'b1;
            P0_OUT <= 8'h00;
            P0_OE_N <= 8'hff;
            P2_OUT <= 8'hff;
            P2_OE_N <= 8'hff;
        end
        else
        begin
            ALE <= ale_d;
            RD_N <= rd_n_d;
            WR_N <= wr_n_d;
            P0_OUT <= p0_out_d;
            P0_OE_N <= p0_oe_n_d;
            P2_OUT <= p2_out_d;
            P2_OE_N <= p2_oe_n_d;
        end
    end

    // configuration status
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            STRETCH <= 3'h0;
            XRAM_ENABLED <= 1'b0;
        end
        else
        begin
            STRETCH <= stretch;
            XRAM_ENABLED <= xen_q;
        end
    end

    // on-chip data SRAM, reached only by data moves
    xds_ram #(
        .AW(`XDS_XRAM_AW),
        .DW(8)
    ) u_xram (
        .clk(CLK),
        .we(xram_we),
        .waddr(cmd_q.addr[`XDS_XRAM_AW-1:0]),
        .wdata(cmd_q.wdata),
        .raddr(cmd_q.addr[`XDS_XRAM_AW-1:0]),
        .rdata(xram_rdata)
    );

    // scratchpad, separate storage
    xds_ram #(
        .AW(`XDS_SCRATCH_AW),
        .DW(8)
    ) u_scratch (
        .clk(CLK),
        .we(scratch_we),
        .waddr(ireg_addr),
        .wdata(new_val),
        .raddr(ireg_addr),
        .rdata(scratch_rdata)
    );

endmodule

`default_nettype wire

// ==== dv/xds_decoder_props.sv ====
`timescale 1ns/1ns
`default_nettype none

module xds_decoder_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // data move
    input wire logic XMOVE_REQ,
    input wire xds_pkg::xds_move_t XMOVE_CMD,
    input wire logic XMOVE_BUSY,
    input wire logic XMOVE_DONE,
    input wire logic XMOVE_ONCHIP,
    // register space
    input wire logic IREG_REQ,
    input wire xds_pkg::xds_ireg_t IREG_CMD,
    input wire logic [7:0] IREG_RDATA,
    input wire logic IREG_REFUSED,
    // bus pins
    input wire logic ALE,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [7:0] P0_OUT,
    input wire logic [7:0] P0_OE_N,
    input wire logic [7:0] P2_OUT,
    input wire logic [7:0] P2_OE_N,
    // configuration
    input wire logic [2:0] STRETCH,
    input wire logic XRAM_ENABLED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    logic acc, hit;
    logic [5:0] cnt_q, exp_q;
    logic [15:0] adr_q;
    assign acc = XMOVE_REQ && !XMOVE_BUSY;
    assign hit = XRAM_ENABLED && XMOVE_CMD.addr <= 16'h03ff;
    // cycles since the last accepted move, and its expected length
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            cnt_q <= 6'h00;
        else
            cnt_q <= acc ? 6'h00 : cnt_q + 6'h01;
    end
    always_ff @(posedge CLK)
    begin
        if (acc)
            exp_q <= hit ? 6'h08 : {1'b0, STRETCH, 2'b00} + 6'h08;
        if (acc)
            adr_q <= XMOVE_CMD.addr;
    end
    move_len_a: assert property (XMOVE_DONE |-> cnt_q == exp_q)
        else $error("move length wrong");
    onchip_sel_a: assert property (acc |=> XMOVE_ONCHIP == $past(hit))
        else $error("move routed wrong");
    ale_pulse_a: assert property (acc && !hit |=> ALE [*2] ##1 !ALE)
        else $error("address strobe wrong");
    p0_addr_a: assert property (acc && !hit |=> P0_OE_N == 8'h00 && P0_OUT == adr_q[7:0])
        else $error("low address not driven");
    p2_addr_a: assert property (XMOVE_BUSY && !XMOVE_ONCHIP |->
        P2_OE_N == 8'h00 && P2_OUT == adr_q[15:8])
        else $error("high address not driven");
    chip_quiet_a: assert property (XMOVE_BUSY && XMOVE_ONCHIP |-> !ALE && RD_N && WR_N)
        else $error("pins move on chip access");
    strobe_idle_a: assert property (!XMOVE_BUSY |-> RD_N && WR_N)
        else $error("strobe outside move");
    bit_refuse_a: assert property (IREG_REQ && IREG_CMD.bitop && !IREG_CMD.indirect
        && IREG_CMD.addr[7] && IREG_CMD.addr[2:0] != 3'h0 |=> IREG_REFUSED && IREG_RDATA == 8'hff)
        else $error("bit op not refused");
endmodule

bind xds_decoder xds_decoder_props u_props (
    .CLK, .RESET, .XMOVE_REQ, .XMOVE_CMD, .XMOVE_BUSY, .XMOVE_DONE, .XMOVE_ONCHIP,
    .IREG_REQ, .IREG_CMD, .IREG_RDATA, .IREG_REFUSED, .ALE, .RD_N, .WR_N,
    .P0_OUT, .P0_OE_N, .P2_OUT, .P2_OE_N, .STRETCH, .XRAM_ENABLED
);

`default_nettype wire

// ==== dv/xds_ext_ram.sv ====
`timescale 1ns/1ns
`default_nettype none

module xds_ext_ram (
    // bus side
    input wire logic clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe_n,
    input wire logic [7:0] p2_out,
    // clocks of read strobe before data is valid
    input wire logic [3:0] wait_clks,
    // resolved port 0 level
    output logic [7:0] p0_pin
);
    logic [7:0] mem [0:65535];
    logic [15:0] adr;
    logic [7:0] last, drv;
    logic [3:0] cnt;
    initial last = 8'h00;
    // undriven bus shows a changing pattern, never a stale value
    assign drv = (!rd_n && cnt >= wait_clks) ? mem[adr] : ~last;
    assign p0_pin = (~p0_oe_n & p0_out) | (p0_oe_n & drv);
    always @(posedge clk)
    begin
        last <= p0_pin;
        cnt <= rd_n ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
        if (ale)
            adr <= {p2_out, p0_out};
        if (!wr_n)
            mem[adr] <= p0_out;
    end
endmodule

`default_nettype wire

// ==== dv/xds_decoder_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t line %0d", $time, `__LINE__); end end

module xds_decoder_bench;
    logic CLK, RESET, XMOVE_REQ, IREG_REQ, XMOVE_BUSY, XMOVE_DONE, XMOVE_ONCHIP;
    logic IREG_DONE, IREG_REFUSED, ALE, RD_N, WR_N, XRAM_ENABLED, rf;
    xds_pkg::xds_move_t XMOVE_CMD;
    xds_pkg::xds_ireg_t IREG_CMD;
    logic [7:0] XMOVE_RDATA, IREG_RDATA, P0_LATCH, P2_LATCH, P0_IN, P0_OUT;
    logic [7:0] P0_OE_N, P2_OUT, P2_OE_N, rd;
    logic [2:0] STRETCH;
    logic [3:0] wait_clks;
    int failures, n_tests, len;

    xds_decoder i_dut (.CLK, .RESET, .XMOVE_REQ, .XMOVE_CMD, .XMOVE_BUSY, .XMOVE_DONE,
        .XMOVE_RDATA, .XMOVE_ONCHIP, .IREG_REQ, .IREG_CMD, .IREG_DONE, .IREG_RDATA,
        .IREG_REFUSED, .P0_LATCH, .P2_LATCH, .ALE, .RD_N, .WR_N, .P0_IN, .P0_OUT,
        .P0_OE_N, .P2_OUT, .P2_OE_N, .STRETCH, .XRAM_ENABLED);
    xds_ext_ram i_ram (.clk(CLK), .ale(ALE), .rd_n(RD_N), .wr_n(WR_N), .p0_out(P0_OUT),
        .p0_oe_n(P0_OE_N), .p2_out(P2_OUT), .wait_clks, .p0_pin(P0_IN));

    task automatic give_verdict;
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // f is {write, indirect, bitop}
    task automatic ireg(input logic [2:0] f, input logic [2:0] bs, input logic bv,
        input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        IREG_REQ = 1'b1;
        IREG_CMD = {f, bs, bv, a, d};
        @(negedge CLK);
        IREG_REQ = 1'b0;
        `CHK(IREG_DONE, 1'b1)
        rd = IREG_RDATA;
        rf = IREG_REFUSED;
    endtask

    task automatic move(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge CLK);
        XMOVE_REQ = 1'b1;
        XMOVE_CMD = {w, a, d};
        @(negedge CLK);
        XMOVE_REQ = 1'b0;
        len = 1;
        while (XMOVE_DONE !== 1'b1 && len < 60)
        begin
            @(negedge CLK);
            len++;
        end
        if (len >= 60)
        begin
            failures++;
            give_verdict();
        end
        len--;
        rd = XMOVE_RDATA;
    endtask

    task automatic t_reset;
        `CHK(XRAM_ENABLED, 1'b0)
        `CHK(STRETCH, 3'h1)
        `CHK(P0_OE_N, P0_LATCH)
        `CHK(P2_OUT, P2_LATCH)
        ireg(3'b000, 3'h0, 1'b0, 8'hc4, 8'h00);
        `CHK(rd, 8'hfe)
        ireg(3'b000, 3'h0, 1'b0, 8'hb9, 8'h00);
        `CHK(rd, 8'hff)
        move(1'b1, 16'h0123, 8'h5a);
        `CHK(len, 12)
        move(1'b0, 16'h0123, 8'h00);
        `CHK(rd, 8'h5a)
        `CHK(XMOVE_ONCHIP, 1'b0)
    endtask

    task automatic t_stretch;
        for (int s = 0; s < 8; s++)
        begin
            // slowest device that the read sample of this stretch still meets
            wait_clks = (s < 4) ? 4'(4 * s + 2) : 4'hf;
            ireg(3'b100, 3'h0, 1'b0, 8'h8e, 8'(s));
            // status output follows the register one clock later
            @(negedge CLK);
            `CHK(STRETCH, 3'(s))
            move(1'b1, 16'h8000 + 16'(s), 8'(s) ^ 8'ha5);
            `CHK(len, 4 * (s + 2))
            move(1'b0, 16'h8000 + 16'(s), 8'h00);
            `CHK(rd, 8'(s) ^ 8'ha5)
        end
    endtask

    task automatic t_onchip;
        move(1'b1, 16'h03ff, 8'h11);
        ireg(3'b100, 3'h0, 1'b0, 8'hc4, 8'h01);
        @(negedge CLK);
        `CHK(XRAM_ENABLED, 1'b1)
        move(1'b1, 16'h03ff, 8'h22);
        `CHK(len, 8)
        move(1'b0, 16'h03ff, 8'h00);
        `CHK(rd, 8'h22)
        `CHK(XMOVE_ONCHIP, 1'b1)
        move(1'b0, 16'h0400, 8'h00);
        `CHK(XMOVE_ONCHIP, 1'b0)
        ireg(3'b100, 3'h0, 1'b0, 8'hc4, 8'h00);
        move(1'b0, 16'h03ff, 8'h00);
        `CHK(rd, 8'h11)
    endtask

    task automatic t_regs;
        ireg(3'b100, 3'h0, 1'b0, 8'h8e, 8'h03);
        ireg(3'b110, 3'h0, 1'b0, 8'h8e, 8'h77);
        `CHK(STRETCH, 3'h3)
        ireg(3'b010, 3'h0, 1'b0, 8'h8e, 8'h00);
        `CHK(rd, 8'h77)
        ireg(3'b101, 3'h1, 1'b1, 8'h8e, 8'h00);
        `CHK({rf, rd}, 9'h1ff)
        ireg(3'b000, 3'h0, 1'b0, 8'h8e, 8'h00);
        `CHK(rd, 8'h03)
        ireg(3'b100, 3'h0, 1'b0, 8'h20, 8'h81);
        ireg(3'b101, 3'h3, 1'b1, 8'h20, 8'h00);
        `CHK(rf, 1'b0)
        ireg(3'b000, 3'h0, 1'b0, 8'h20, 8'h00);
        `CHK(rd, 8'h89)
        ireg(3'b001, 3'h5, 1'b0, 8'h88, 8'h00);
        `CHK({rf, rd}, 9'h001)
    endtask

    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    initial
    begin
        RESET = 1'b1;
        XMOVE_REQ = 1'b0;
        IREG_REQ = 1'b0;
        XMOVE_CMD = '0;
        IREG_CMD = '0;
        P0_LATCH = 8'h0f;
        P2_LATCH = 8'h3c;
        wait_clks = 4'h0;
        failures = 0;
        n_tests = 0;
        repeat (16) @(negedge CLK);
        RESET = 1'b0;
        @(negedge CLK);
        t_reset();
        t_stretch();
        t_onchip();
        t_regs();
        give_verdict();
    end
endmodule

`default_nettype wire
